// ---- light_curtain_safety_control.sv ----
// Safety light curtain control: two final switch outputs, monitor, restart
// interlock, lockout and indicator drive.
// Assumes beam and fault status come from other logic on this clock;
// test and restart contacts arrive raw from terminals.
// How it works
// R01: Open test input stops emission, outputs off
// R02: Monitor follows test input application and withdrawal
// R03: Restart shorted: outputs follow beam state
// R04: Restart open: interruption latches outputs off
// R05: Shorting restart releases latch if beams clear
// R06: Lockout entered after up to 500 ms
// R07: Machine ignores outputs first second after power
// R08: Emitting lamp steady, blinks on emitter fault
// R09: Stable lamp only when all beams stable
// R10: Unstable lamp when any beam marginal
// R11: Red lamp on interruption, blinks on extraneous light
// R12: Receiver fault rotates stable, unstable, operation blink
// R13: Sync break or emitter fault alternates two lamps
// R14: Yellow switching lamp lit when outputs off
// R15: Lockout lamp lit throughout lockout
// R16: Green lamp when output on, red when off
// R17: Any fault or interruption opens both outputs
// R18: Monitor always opposite of final switch outputs
// R19: Test and restart contacts synchronized and debounced
`timescale 1ns/1ps
`default_nettype none
module light_curtain_safety_control
  import curtain_pkg::*;
#(
  parameter int DEBOUNCE_COUNT = DEBOUNCE_CYCLES,
  parameter int LOCKOUT_COUNT  = LOCKOUT_CYCLES,
  parameter int BLINK_COUNT    = BLINK_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic test_closed,
  input  wire logic restart_closed,
  input  wire logic beams_clear,
  input  wire logic beams_stable,
  input  wire logic beams_marginal,
  input  wire logic extraneous_light,
  input  wire logic emitter_fault,
  input  wire logic receiver_fault,
  input  wire logic sync_broken,
  input  wire logic cable_fault,
  input  wire logic relay_mismatch,
  output logic      emit_enable,
  output logic      final_switch_output_1,
  output logic      final_switch_output_2,
  output logic      monitor_output,
  output logic      lockout_output,
  output logic      emit_lamp,
  output logic      stable_lamp,
  output logic      unstable_lamp,
  output logic      operation_lamp,
  output logic      open_lamp,
  output logic      lockout_lamp,
  output logic      incident_lamp,
  output logic      switch_red_lamp
);
  localparam int DW = $clog2(DEBOUNCE_COUNT + 1);
  localparam int LW = $clog2(LOCKOUT_COUNT + 1);
  localparam int BW = $clog2(BLINK_COUNT + 1);

  // Synchronizers: stage one is read only by stage two
  logic [1:0] sync_a, sync_b;
  logic [1:0] deb, next_deb;
  logic [DW-1:0] deb_cnt [2];
  logic [DW-1:0] next_deb_cnt [2];
  logic [1:0] raw_in;
  assign raw_in = {restart_closed, test_closed};

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
    end else begin
      sync_a <= raw_in; // [R19]
      sync_b <= sync_a;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_deb
      always_comb begin
        next_deb[g]     = deb[g];
        next_deb_cnt[g] = deb_cnt[g];
        if (sync_b[g] == deb[g]) begin
          next_deb_cnt[g] = '0;
        end else if (deb_cnt[g] == DW'(DEBOUNCE_COUNT - 1)) begin
          next_deb[g]     = sync_b[g]; // [R19]
          next_deb_cnt[g] = '0;
        end else begin
          next_deb_cnt[g] = deb_cnt[g] + DW'(1);
        end
      end
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          deb[g]     <= 1'b0;
          deb_cnt[g] <= '0;
        end else begin
          deb[g]     <= next_deb[g];
          deb_cnt[g] <= next_deb_cnt[g];
        end
      end
    end
  endgenerate

  logic test_ok, restart_ok;
  assign test_ok    = deb[0];
  assign restart_ok = deb[1];

  // Any trip condition opens the outputs; an open test input counts as one
  logic trip, fault;
  assign fault = emitter_fault | receiver_fault | sync_broken | cable_fault;
  assign trip  = !beams_clear | fault | extraneous_light | !test_ok; // [R01] [R17]

  mode_e mode, next_mode;
  logic [LW-1:0] lock_cnt, next_lock_cnt;
  logic out_on, next_out_on;

  always_comb begin
    next_mode     = mode;
    next_lock_cnt = '0;
    next_out_on   = 1'b0;
    case (mode)
      ST_RUN: begin
        next_out_on = !trip; // [R03]
        if (trip && !restart_ok) begin
          next_mode   = ST_LATCH; // [R04]
          next_out_on = 1'b0;
        end
      end
      ST_LATCH: begin
        if (restart_ok && !trip) begin
          next_mode   = ST_RUN; // [R05]
          next_out_on = 1'b1;
        end
      end
      ST_LOCK: begin
        next_mode = ST_LOCK;
      end
      default: next_mode = ST_LATCH;
    endcase
    // Sustained fault or relay mismatch leads to lockout after the system delay
    if (mode != ST_LOCK && (fault || relay_mismatch)) begin
      if (lock_cnt == LW'(LOCKOUT_COUNT - 1)) begin
        next_mode   = ST_LOCK; // [R06]
        next_out_on = 1'b0;
      end else begin
        next_lock_cnt = lock_cnt + LW'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode     <= ST_LATCH;
      lock_cnt <= '0;
      out_on   <= 1'b0;
    end else begin
      mode     <= next_mode;
      lock_cnt <= next_lock_cnt;
      out_on   <= next_out_on;
    end
  end

  // Blink divider: blink level toggles every half period, plus a rotation phase
  logic [BW-1:0] blink_cnt, next_blink_cnt;
  logic blink, next_blink;
  logic [1:0] rot, next_rot;

  always_comb begin
    next_blink_cnt = blink_cnt + BW'(1);
    next_blink     = blink;
    next_rot       = rot;
    if (blink_cnt == BW'(BLINK_COUNT - 1)) begin
      next_blink_cnt = '0;
      next_blink     = !blink;
      next_rot       = (rot == 2'h2) ? 2'h0 : rot + 2'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      blink_cnt <= '0;
      blink     <= 1'b0;
      rot       <= ROT_RESET;
    end else begin
      blink_cnt <= next_blink_cnt;
      blink     <= next_blink;
      rot       <= next_rot;
    end
  end

  // Indicator and output registers; every output is a flop
  logic [12:0] next_outs;
  always_comb begin
    logic stab, unst, oper;
    stab = beams_clear && beams_stable && !beams_marginal; // [R09]
    unst = beams_marginal; // [R10]
    oper = extraneous_light ? blink : !beams_clear; // [R11]
    if (receiver_fault) begin
      stab = blink && rot == 2'h0; // [R12]
      unst = blink && rot == 2'h1;
      oper = blink && rot == 2'h2;
    end else if (sync_broken || emitter_fault) begin
      unst = blink; // [R13]
      oper = !blink;
    end
    next_outs = {
      test_ok,                             // Emission runs only with test closed
      next_out_on, next_out_on,
      !next_out_on,                        // [R18] [R02]
      next_mode == ST_LOCK,
      emitter_fault ? blink : test_ok,     // [R08]
      stab, unst, oper,
      !next_out_on,                        // [R14]
      next_mode == ST_LOCK,                // [R15]
      next_out_on, !next_out_on            // [R16]
    };
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      {emit_enable, final_switch_output_1, final_switch_output_2, monitor_output,
       lockout_output, emit_lamp, stable_lamp, unstable_lamp, operation_lamp,
       open_lamp, lockout_lamp, incident_lamp, switch_red_lamp} <= OUTS_RESET;
    end else begin
      {emit_enable, final_switch_output_1, final_switch_output_2, monitor_output,
       lockout_output, emit_lamp, stable_lamp, unstable_lamp, operation_lamp,
       open_lamp, lockout_lamp, incident_lamp, switch_red_lamp} <= next_outs;
    end
  end
endmodule // light_curtain_safety_control
`default_nettype wire

// ---- curtain_pkg.sv ----
// Constants shared by the light curtain safety control block.
// Assumes a single 200 MHz system clock.
package curtain_pkg;
  localparam int  CLOCK_HZ          = 200_000_000;
  // Debounce time for the test and restart contacts, microseconds
  localparam int  DEBOUNCE_US       = 10_000;
  localparam int  DEBOUNCE_CYCLES   = DEBOUNCE_US * (CLOCK_HZ / 1_000_000);
  // Lockout entry delay, milliseconds
  localparam int  LOCKOUT_MS        = 500;
  localparam int  LOCKOUT_CYCLES    = LOCKOUT_MS * (CLOCK_HZ / 1000);
  // Indicator blink half period, milliseconds
  localparam int  BLINK_MS          = 250;
  localparam int  BLINK_CYCLES      = BLINK_MS * (CLOCK_HZ / 1000);
  localparam logic [1:0] ROT_RESET  = 2'h0;
  // Reset value of the registered outputs, first port first: all outputs off,
  // monitor, operation, open and red switching lamps lit
  localparam logic [12:0] OUTS_RESET = 13'h0219;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_LATCH  = 2'b01,
    ST_LOCK   = 2'b11
  } mode_e;
endpackage

// ---- relay_model.sv ----
// Model of the machine primary relay contacts.
// Expects the final switch output as coil drive, on the same clock.
`timescale 1ns/1ps
`default_nettype none
module relay_model (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic coil,
  input  wire logic weld,
  output logic      mismatch
);
  logic contact;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) contact <= 1'b0;
    else if (!weld) contact <= coil;
  end
  // Lag of one cycle gives short pulses, far below the lockout delay
  assign mismatch = contact != coil;
endmodule // relay_model
`default_nettype wire

// ---- curtain_monitor.sv ----
// Output checks for the light curtain control.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module curtain_monitor (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic beams_clear,
  input wire logic cable_fault,
  input wire logic beams_stable,
  input wire logic beams_marginal,
  input wire logic extraneous_light,
  input wire logic emitter_fault,
  input wire logic receiver_fault,
  input wire logic sync_broken,
  input wire logic emit_lamp,
  input wire logic stable_lamp,
  input wire logic unstable_lamp,
  input wire logic operation_lamp,
  input wire logic emit_enable,
  input wire logic final_switch_output_1,
  input wire logic final_switch_output_2,
  input wire logic monitor_output,
  input wire logic lockout_output,
  input wire logic open_lamp,
  input wire logic lockout_lamp,
  input wire logic incident_lamp,
  input wire logic switch_red_lamp
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_trip; !beams_clear || cable_fault; endsequence
  property p_trip; s_trip |=> !final_switch_output_1; endproperty
  a_trip: assert property (p_trip) else $error("on after trip");
  property p_pair; final_switch_output_1 == final_switch_output_2; endproperty
  a_pair: assert property (p_pair) else $error("outputs differ");
  property p_mon; monitor_output != final_switch_output_1; endproperty
  a_mon: assert property (p_mon) else $error("monitor");
  property p_open; open_lamp == !final_switch_output_1; endproperty
  a_open: assert property (p_open) else $error("open lamp");
  property p_ind; incident_lamp == final_switch_output_1 && switch_red_lamp != incident_lamp;
  endproperty
  a_ind: assert property (p_ind) else $error("incident lamps");
  property p_lock; lockout_lamp == lockout_output; endproperty
  a_lock: assert property (p_lock) else $error("lockout lamp");
  property p_lockoff; lockout_output |-> !final_switch_output_1; endproperty
  a_lockoff: assert property (p_lockoff) else $error("on in lockout");
  property p_emit; !emit_enable |-> !final_switch_output_1; endproperty
  a_emit: assert property (p_emit) else $error("on without emission");
  // Only reset leaves lockout
  property p_lockhold; lockout_output |=> lockout_output; endproperty
  a_lockhold: assert property (p_lockhold) else $error("lockout left");
  // Steady lamp drive holds only while no sensor fault pattern overrides it
  sequence s_quiet; !receiver_fault && !sync_broken && !emitter_fault; endsequence
  property p_stable;
    !receiver_fault |=> stable_lamp == $past(beams_clear && beams_stable && !beams_marginal);
  endproperty
  a_stable: assert property (p_stable) else $error("stable lamp");
  property p_unstable; s_quiet |=> unstable_lamp == $past(beams_marginal); endproperty
  a_unstable: assert property (p_unstable) else $error("unstable lamp");
  property p_oper; s_quiet ##0 !extraneous_light |=> operation_lamp == !$past(beams_clear);
  endproperty
  a_oper: assert property (p_oper) else $error("operation lamp");
  property p_rotate;
    receiver_fault |=> $onehot0({stable_lamp, unstable_lamp, operation_lamp});
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotation lamps");
  property p_alt;
    (sync_broken || emitter_fault) && !receiver_fault |=> unstable_lamp != operation_lamp;
  endproperty
  a_alt: assert property (p_alt) else $error("alternate lamps");
  property p_emitlamp; !emitter_fault |=> emit_lamp == emit_enable; endproperty
  a_emitlamp: assert property (p_emitlamp) else $error("emitting lamp");
endmodule // curtain_monitor
bind light_curtain_safety_control curtain_monitor u_mon (
  .clock                 (clock),
  .rst_b                 (rst_b),
  .beams_clear           (beams_clear),
  .cable_fault           (cable_fault),
  .beams_stable          (beams_stable),
  .beams_marginal        (beams_marginal),
  .extraneous_light      (extraneous_light),
  .emitter_fault         (emitter_fault),
  .receiver_fault        (receiver_fault),
  .sync_broken           (sync_broken),
  .emit_lamp             (emit_lamp),
  .stable_lamp           (stable_lamp),
  .unstable_lamp         (unstable_lamp),
  .operation_lamp        (operation_lamp),
  .emit_enable           (emit_enable),
  .final_switch_output_1 (final_switch_output_1),
  .final_switch_output_2 (final_switch_output_2),
  .monitor_output        (monitor_output),
  .lockout_output        (lockout_output),
  .open_lamp             (open_lamp),
  .lockout_lamp          (lockout_lamp),
  .incident_lamp         (incident_lamp),
  .switch_red_lamp       (switch_red_lamp)
);
`default_nettype wire

// ---- test_light_curtain_safety_control.sv ----
// Self-checking bench for the light curtain control.
// Short debounce, lockout and blink counts; relay_model closes the loop.
`timescale 1ns/1ps
`default_nettype none
module test_light_curtain_safety_control;
  logic       clock = 0, rst_b = 0, test_closed = 1, restart_closed = 1, beams_clear = 1;
  logic       beams_stable = 1, beams_marginal = 0, weld = 0, req = 0, b, mismatch;
  logic       fso1, mon, lock;
  logic [4:0] flt = 0;
  logic [1:0] q[$];
  logic [1:0] e;
  int         failures = 0, n_checks = 0;
  integer     seed = 32'hcf56;
  always #2.5 clock = ~clock;
  light_curtain_safety_control #(.DEBOUNCE_COUNT(4), .LOCKOUT_COUNT(20), .BLINK_COUNT(3)) u_dut (
    .clock, .rst_b, .test_closed, .restart_closed, .beams_clear, .beams_stable, .beams_marginal,
    .extraneous_light(flt[4]), .emitter_fault(flt[3]), .receiver_fault(flt[2]),
    .sync_broken(flt[1]), .cable_fault(flt[0]), .relay_mismatch(mismatch), .emit_enable(),
    .final_switch_output_1(fso1), .final_switch_output_2(), .monitor_output(mon),
    .lockout_output(lock), .emit_lamp(), .stable_lamp(), .unstable_lamp(), .operation_lamp(),
    .open_lamp(), .lockout_lamp(), .incident_lamp(), .switch_red_lamp());
  relay_model u_relay (.clock, .rst_b, .coil(fso1), .weld, .mismatch);
  task automatic ck(input logic [1:0] v, input int w);
    repeat (w) @(posedge clock);
    q.push_back(v);
    req <= 1;
    @(posedge clock);
    req <= 0;
  endtask
  task automatic wrap_up;
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Expected value holds {output on, lockout}; monitor must be the inverse
  always @(posedge clock) if (req) begin
    e = q.pop_front();
    n_checks++;
    if ({fso1, lock} !== e || mon !== !e[1]) begin
      failures++;
      $display("Error outputs expected %b seen %b monitor %b", e, {fso1, lock}, mon);
    end
  end
  initial begin
    repeat (2) @(posedge clock);
    rst_b <= 1;
    // Nothing is judged before the outputs have had time to settle
    ck(2'b10, 12);
    beams_clear <= 0; ck(2'b00, 2);
    beams_clear <= 1; ck(2'b10, 2);
    restart_closed <= 0; beams_clear <= 0; ck(2'b00, 12);
    beams_clear <= 1; ck(2'b00, 3);
    restart_closed <= 1; ck(2'b10, 12);
    test_closed <= 0; ck(2'b00, 12);
    test_closed <= 1; ck(2'b10, 12);
    for (int i = 0; i < 5; i++) begin
      flt <= 5'h1 << i; ck(2'b00, 2);
      flt <= 0; ck(2'b10, 2);
    end
    for (int i = 0; i < 8; i++) begin
      b = 1'($random(seed));
      beams_clear <= b;
      beams_stable <= 1'($random(seed));
      beams_marginal <= 1'($random(seed));
      ck({b, 1'b0}, 2);
    end
    beams_clear <= 1; ck(2'b10, 2);
    weld <= 1; beams_clear <= 0; ck(2'b00, 2);
    // Welded contact: twenty mismatch cycles, lockout on the edge after
    ck(2'b00, 17);
    ck(2'b01, 1);
    beams_clear <= 1; ck(2'b01, 12);
    rst_b <= 0; weld <= 0; ck(2'b00, 2);
    rst_b <= 1; ck(2'b10, 12);
    wrap_up;
  end
  initial begin
    repeat (2000) @(posedge clock);
    failures++;
    wrap_up;
  end
endmodule // test_light_curtain_safety_control
`default_nettype wire
